//--- core/txfc_top.sv
// Transmit framer with PHY control, LED and link settings
//
// Summary of operation
// - Echo-off honoured only when loop, duplex clear
// - Force bit reports link up
// - Jabber-off bit suppresses jabber cut
// - LED outputs follow LED configuration register
// - MAC generates preamble and delimiter
// - Pad and CRC only when configured
// - One control byte per frame, consumed
// - Override pad bit pads to 60
// - Override CRC bit appends; else checks unpadded frames
// - Global CRC enable appends CRC unless control byte overrides
// - Pad field selects 60, 64 or none
//
// Implementation choices: the plain strobed port and the register offsets.
`timescale 1ns/100ps
module txfc_top
  import txfc_pkg::*;
#(
  parameter int JABBER_LIMIT = JABBER_CYC
) (
  input  wire logic        clock,
  input  wire logic        rst,
  input  wire logic [3:0]  reg_addr,
  input  wire logic [15:0] reg_wdata,
  input  wire logic        reg_wr,
  input  wire logic        reg_rd,
  output logic      [15:0] reg_rdata,
  input  wire logic        buf_valid,
  input  wire logic [7:0]  buf_data,
  input  wire logic        buf_last,
  output logic             buf_ready,
  input  wire logic        link_pin,
  output logic             tp_tx_en,
  output logic      [7:0]  tp_tx_data,
  output logic             loop_valid,
  output logic      [7:0]  loop_data,
  output logic             link_up,
  output logic             led_out_first,
  output logic             led_out_second
);
  function automatic logic [31:0] crc_byte(logic [31:0] c, logic [7:0] d);
    logic [31:0] r;
    r = c ^ {24'h000000, d};
    for (int i = 0; i < 8; i++) begin
      r = r[0] ? ((r >> 1) ^ CRC_POLY) : (r >> 1);
    end
    return r;
  endfunction

  function automatic logic led_drive(logic [3:0] m, logic lk, logic tx);
    return (m == LED_LINK) ? lk : (m == LED_TX) ? tx : (m == LED_ON);
  endfunction

  logic [15:0] phy_control_one_r, phy_control_one_nxt;
  logic [15:0] phy_control_two_r, phy_control_two_nxt;
  logic [7:0]  mac_control_three_r, mac_control_three_nxt;
  logic [15:0] led_config_reg_r, led_config_reg_nxt;
  logic [15:0] max_frame_len_r, max_frame_len_nxt;
  logic [2:0]  sticky_r, sticky_nxt;
  logic [15:0] rdata_nxt;
  logic        link_s1_r, link_s2_r;

  txfc_state_t state_r, state_nxt;
  logic [15:0] cnt_r, cnt_nxt;
  logic [2:0]  sub_r, sub_nxt;
  logic [31:0] crc_r, crc_nxt;
  logic        pad_en_r, pad_en_nxt, crc_en_r, crc_en_nxt;
  logic        huge_r, huge_nxt, long_pad_r, long_pad_nxt;
  logic [22:0] jab_r, jab_nxt;
  logic        ready_nxt, wv_nxt;
  logic [7:0]  wd_nxt;
  logic        ev_crce, ev_giant, ev_jab;
  logic        take, fdx_stat, link_nxt;
  logic [15:0] status_w;
  logic        tx_on_r, tp_en_nxt, loop_nxt;

  assign take = buf_valid && buf_ready;
  assign fdx_stat = mac_control_three_r[MC3_FDX_BIT];

  // Register file
  always_comb begin
    phy_control_one_nxt   = phy_control_one_r;
    phy_control_two_nxt   = phy_control_two_r;
    mac_control_three_nxt = mac_control_three_r;
    led_config_reg_nxt    = led_config_reg_r;
    max_frame_len_nxt     = max_frame_len_r;
    sticky_nxt            = sticky_r;
    if (reg_wr) begin
      unique case (reg_addr)
        REG_PHY_CTL_ONE: phy_control_one_nxt = reg_wdata;
        REG_PHY_CTL_TWO: phy_control_two_nxt = reg_wdata & PC2_WR_MASK;
        REG_MAC_CTL_THR: mac_control_three_nxt = reg_wdata[7:0];
        REG_LED_CFG:     led_config_reg_nxt = reg_wdata;
        REG_MAX_LEN:     max_frame_len_nxt = reg_wdata;
        REG_STATUS:      sticky_nxt = sticky_r & ~reg_wdata[ST_JAB:ST_CRCE];
        default:         ;
      endcase
    end
    // Set wins over write-one-to-clear
    sticky_nxt = sticky_nxt | {ev_jab, ev_giant, ev_crce};
    status_w = {11'h000, sticky_r, link_up, state_r != TXFC_IDLE};
    rdata_nxt = 16'h0000;
    if (reg_rd) begin
      unique case (reg_addr)
        REG_PHY_CTL_ONE: rdata_nxt = phy_control_one_r;
        REG_PHY_CTL_TWO: rdata_nxt = phy_control_two_r;
        REG_MAC_CTL_THR: rdata_nxt = {8'h00, mac_control_three_r};
        REG_LED_CFG:     rdata_nxt = led_config_reg_r;
        REG_MAX_LEN:     rdata_nxt = max_frame_len_r;
        REG_STATUS:      rdata_nxt = status_w;
        default:         rdata_nxt = 16'h0000;
      endcase
    end
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      phy_control_one_r   <= 16'h0000;
      phy_control_two_r   <= 16'h0000;
      mac_control_three_r <= 8'h00;
      led_config_reg_r    <= LED_RESET;
      max_frame_len_r     <= MAXLEN_RST;
      sticky_r            <= 3'h0;
      reg_rdata           <= 16'h0000;
    end else begin
      phy_control_one_r   <= phy_control_one_nxt;
      phy_control_two_r   <= phy_control_two_nxt;
      mac_control_three_r <= mac_control_three_nxt;
      led_config_reg_r    <= led_config_reg_nxt;
      max_frame_len_r     <= max_frame_len_nxt;
      sticky_r            <= sticky_nxt;
      reg_rdata           <= rdata_nxt;
    end
  end

  // Frame engine
  always_comb begin
    logic [2:0]  pcfg;
    logic [7:0]  cb;
    logic [31:0] c1;
    pcfg = mac_control_three_r[MC3_PAD_LSB +: 3];
    cb = buf_data;
    c1 = crc_byte(crc_r, buf_data);
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    sub_nxt = sub_r;
    crc_nxt = crc_r;
    pad_en_nxt = pad_en_r;
    crc_en_nxt = crc_en_r;
    huge_nxt = huge_r;
    long_pad_nxt = long_pad_r;
    wv_nxt = 1'b0;
    wd_nxt = 8'h00;
    ev_crce = 1'b0;
    ev_giant = 1'b0;
    ev_jab = 1'b0;
    jab_nxt = (state_r == TXFC_IDLE) ? 23'h000000 : jab_r + 23'h000001;
    unique case (state_r)
      TXFC_IDLE: begin
        if (take) begin
          state_nxt = TXFC_PRE;
          sub_nxt = 3'h0;
          cnt_nxt = 16'h0000;
          crc_nxt = CRC_INIT;
          if (cb[CB_OVR]) begin
            pad_en_nxt = cb[CB_PAD];
            long_pad_nxt = 1'b0;
            crc_en_nxt = cb[CB_CRC];
            huge_nxt = cb[CB_HUGE];
          end else begin
            pad_en_nxt = pcfg[0];
            long_pad_nxt = pcfg[1];
            crc_en_nxt = mac_control_three_r[MC3_CRC_BIT] | pcfg[0];
            huge_nxt = mac_control_three_r[MC3_HUGE_BIT];
          end
        end
      end
      TXFC_PRE: begin
        wv_nxt = 1'b1;
        wd_nxt = PREAMBLE_BYTE;
        sub_nxt = sub_r + 3'h1;
        if (sub_r == PREAMBLE_LEN - 3'h1) begin
          state_nxt = TXFC_SFD;
        end
      end
      TXFC_SFD: begin
        wv_nxt = 1'b1;
        wd_nxt = SFD_BYTE;
        state_nxt = TXFC_DATA;
      end
      TXFC_DATA: begin
        if (take) begin
          wv_nxt = 1'b1;
          wd_nxt = buf_data;
          crc_nxt = c1;
          cnt_nxt = cnt_r + 16'h0001;
          if (!huge_r && cnt_r >= max_frame_len_r) begin
            ev_giant = 1'b1;
            wv_nxt = 1'b0;
            state_nxt = TXFC_IDLE;
          end else if (buf_last) begin
            // pad and CRC only when enabled
            if (pad_en_r && cnt_nxt < (long_pad_r ? PAD_LONG : PAD_SHORT)) begin
              state_nxt = TXFC_PAD;
            end else if (crc_en_r) begin
              state_nxt = TXFC_FCS;
              sub_nxt = 3'h0;
            end else begin
              ev_crce = (c1 != CRC_RESIDUE);
              state_nxt = TXFC_IDLE;
            end
          end
        end
      end
      TXFC_PAD: begin
        wv_nxt = 1'b1;
        crc_nxt = crc_byte(crc_r, 8'h00);
        cnt_nxt = cnt_r + 16'h0001;
        sub_nxt = 3'h0;
        if (cnt_nxt >= (long_pad_r ? PAD_LONG : PAD_SHORT)) begin
          state_nxt = crc_en_r ? TXFC_FCS : TXFC_IDLE;
        end
      end
      TXFC_FCS: begin
        wv_nxt = 1'b1;
        wd_nxt = ~crc_r[7:0];
        crc_nxt = {8'hff, crc_r[31:8]};
        sub_nxt = sub_r + 3'h1;
        if (sub_r == 3'h3) begin
          state_nxt = TXFC_IDLE;
        end
      end
      default: state_nxt = TXFC_IDLE;
    endcase
    if (state_r != TXFC_IDLE && jab_r >= 23'(JABBER_LIMIT)
        && !phy_control_two_r[PC2_JAB_OFF]) begin
      ev_jab = 1'b1;
      wv_nxt = 1'b0;
      state_nxt = TXFC_IDLE;
    end
    ready_nxt = (state_nxt == TXFC_IDLE) || (state_nxt == TXFC_DATA);
    tp_en_nxt = wv_nxt && !phy_control_two_r[PC2_TX_OFF];
    // echo-off honoured only with both clear
    if (phy_control_one_r[PC1_DUPLEX_BIT] || phy_control_one_r[PC1_LOOP_BIT])
      loop_nxt = wv_nxt && phy_control_one_r[PC1_LOOP_BIT];
    else
      loop_nxt = wv_nxt && !phy_control_two_r[PC2_ECHO_OFF];
    link_nxt = link_s2_r || phy_control_two_r[PC2_FRC_LINK];
  end

  always_ff @(posedge clock) begin
    if (rst) begin
      state_r <= TXFC_IDLE;
      cnt_r <= 16'h0000;
      sub_r <= 3'h0;
      crc_r <= CRC_INIT;
      pad_en_r <= 1'b0;
      crc_en_r <= 1'b0;
      huge_r <= 1'b0;
      long_pad_r <= 1'b0;
      jab_r <= 23'h000000;
      buf_ready <= 1'b0;
      tp_tx_en <= 1'b0;
      tp_tx_data <= 8'h00;
      loop_valid <= 1'b0;
      loop_data <= 8'h00;
      tx_on_r <= 1'b0;
      link_s1_r <= 1'b0;
      link_s2_r <= 1'b0;
      link_up <= 1'b0;
      led_out_first <= 1'b0;
      led_out_second <= 1'b0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
      sub_r <= sub_nxt;
      crc_r <= crc_nxt;
      pad_en_r <= pad_en_nxt;
      crc_en_r <= crc_en_nxt;
      huge_r <= huge_nxt;
      long_pad_r <= long_pad_nxt;
      jab_r <= jab_nxt;
      buf_ready <= ready_nxt;
      tp_tx_en <= tp_en_nxt;
      tp_tx_data <= tp_en_nxt ? wd_nxt : 8'h00;
      loop_valid <= loop_nxt;
      loop_data <= loop_nxt ? wd_nxt : 8'h00;
      tx_on_r <= wv_nxt;
      link_s1_r <= link_pin;
      link_s2_r <= link_s1_r;
      link_up <= link_nxt;
      led_out_first <= led_drive(led_config_reg_r[11:8], link_up, tx_on_r);
      led_out_second <= led_drive(led_config_reg_r[7:4], link_up, tx_on_r);
    end
  end

  default clocking cb_clk @(posedge clock); endclocking
  default disable iff (rst);

  AST_PRE_FIRST: assert property (state_r == TXFC_IDLE && take |=>
    state_r == TXFC_PRE ##7 state_r == TXFC_SFD) else $error("preamble len");
  AST_CTRL_EATEN: assert property (state_r == TXFC_IDLE && take |=>
    !tx_on_r) else $error("control byte sent");
  AST_FORCE_LINK: assert property (phy_control_two_r[PC2_FRC_LINK] |=>
    link_up) else $error("force link ignored");
  AST_TX_OFF: assert property (phy_control_two_r[PC2_TX_OFF] |=>
    !tp_tx_en) else $error("pair driven while off");
  AST_ECHO_OFF: assert property (phy_control_two_r[PC2_ECHO_OFF]
    && phy_control_one_r[15:8] == 8'h00 |=> !loop_valid)
    else $error("echo while disabled");
  AST_FCS_LEN: assert property ($rose(state_r == TXFC_FCS) |->
    (state_r == TXFC_FCS)[*4] ##1 state_r != TXFC_FCS)
    else $error("fcs length");
  AST_NO_CRC: assert property (state_r == TXFC_DATA && !crc_en_r
    |=> state_r != TXFC_FCS) else $error("crc appended");
  AST_PAD60: assert property (state_r == TXFC_PAD && !long_pad_r
    |-> cnt_r < PAD_SHORT) else $error("pad overrun");
  AST_PAD64: assert property (state_r == TXFC_PAD
    |-> cnt_r < PAD_LONG) else $error("long pad overrun");
  AST_TOP_ZERO: assert property (reg_rd && reg_addr == REG_PHY_CTL_TWO
    |=> !reg_rdata[15]) else $error("reserved top bit");
  AST_OVR: assert property (state_r == TXFC_IDLE && take
    && buf_data[CB_OVR] |=> crc_en_r == $past(buf_data[CB_CRC]))
    else $error("override ignored");
  AST_GCRC: assert property (state_r == TXFC_IDLE && take && !buf_data[0]
    && mac_control_three_r[MC3_CRC_BIT] |=> crc_en_r)
    else $error("global crc ignored");

  COV_PAD: cover property (state_r == TXFC_PAD ##1 state_r == TXFC_FCS);
  COV_NOCRC: cover property (state_r == TXFC_DATA ##1 sticky_r[0]);
  COV_GIANT: cover property (ev_giant);
  COV_FRAME: cover property (state_r == TXFC_FCS ##1 state_r == TXFC_IDLE);
endmodule

//--- core/txfc_pkg.sv
// Constants for the transmit framer and PHY settings block
package txfc_pkg;
  // Register indices on the register port
  localparam logic [3:0] REG_PHY_CTL_ONE = 4'h0;
  localparam logic [3:0] REG_PHY_CTL_TWO = 4'h1;
  localparam logic [3:0] REG_MAC_CTL_THR = 4'h2;
  localparam logic [3:0] REG_LED_CFG     = 4'h3;
  localparam logic [3:0] REG_MAX_LEN     = 4'h4;
  localparam logic [3:0] REG_STATUS      = 4'h5;
  // Field positions
  localparam int PC1_LOOP_BIT   = 14;
  localparam int PC1_DUPLEX_BIT = 8;
  localparam int PC2_FRC_LINK   = 14;
  localparam int PC2_TX_OFF     = 13;
  localparam int PC2_JAB_OFF    = 10;
  localparam int PC2_ECHO_OFF   = 8;
  localparam int MC3_PAD_LSB    = 5;
  localparam int MC3_CRC_BIT    = 4;
  localparam int MC3_HUGE_BIT   = 2;
  localparam int MC3_FDX_BIT    = 0;
  localparam int CB_HUGE = 3;
  localparam int CB_PAD  = 2;
  localparam int CB_CRC  = 1;
  localparam int CB_OVR  = 0;
  localparam int ST_BUSY = 0;
  localparam int ST_LINK = 1;
  localparam int ST_CRCE = 2;
  localparam int ST_GIANT = 3;
  localparam int ST_JAB  = 4;
  // Reset values and masks
  localparam logic [15:0] PC2_WR_MASK = 16'h7fff;
  localparam logic [15:0] LED_RESET   = 16'h0120;
  localparam logic [15:0] MAXLEN_RST  = 16'h05ee;
  // Frame constants
  localparam logic [7:0]  PREAMBLE_BYTE = 8'h55;
  localparam logic [7:0]  SFD_BYTE      = 8'hd5;
  localparam logic [2:0]  PREAMBLE_LEN  = 3'h7;
  localparam logic [15:0] PAD_SHORT     = 16'h003c;
  localparam logic [15:0] PAD_LONG      = 16'h0040;
  localparam logic [31:0] CRC_INIT      = 32'hffffffff;
  localparam logic [31:0] CRC_POLY      = 32'hedb88320;
  localparam logic [31:0] CRC_RESIDUE   = 32'hdebb20e3;
  // LED modes
  localparam logic [3:0] LED_LINK = 4'h0;
  localparam logic [3:0] LED_TX   = 4'h1;
  localparam logic [3:0] LED_ON   = 4'h2;
  // Timing
  localparam int CLK_MHZ  = 200;
  localparam int JABBER_MS = 20;
  localparam int JABBER_CYC = JABBER_MS * CLK_MHZ * 1000;
  typedef enum logic [2:0] {
    TXFC_IDLE = 3'b000,
    TXFC_PRE  = 3'b001,
    TXFC_SFD  = 3'b010,
    TXFC_DATA = 3'b011,
    TXFC_PAD  = 3'b100,
    TXFC_FCS  = 3'b101
  } txfc_state_t;
endpackage

//--- dv/txfc_host_model.sv
// Host model that loads frames into the transmit buffer stream
`timescale 1ns/100ps
module txfc_host_model (
  input  wire logic       clock,
  input  wire logic       buf_ready,
  output logic            buf_valid,
  output logic      [7:0] buf_data,
  output logic            buf_last
);
  initial begin
    buf_valid = 1'b0;
    buf_data  = 8'h00;
    buf_last  = 1'b0;
  end

  task automatic send(input logic [7:0] ctrl, input logic [7:0] pl[$],
                      input bit slow);
    int i;
    for (i = -1; i < pl.size(); i++) begin
      buf_valid <= 1'b1;
      buf_data  <= (i < 0) ? ctrl : pl[i];
      buf_last  <= (i == pl.size() - 1);
      @(posedge clock iff buf_ready);
      // Released bus shows a changed byte, never the stale one
      if (slow || i == pl.size() - 1) begin
        buf_valid <= 1'b0;
        buf_last  <= 1'b0;
        buf_data  <= ~buf_data;
      end
      if (slow) @(posedge clock);
    end
  endtask
endmodule

//--- dv/txfc_top_tb.sv
// Self-checking bench for the transmit framer and PHY settings block
`timescale 1ns/100ps
module txfc_top_tb;
  import txfc_pkg::*;
  logic        clock;
  logic        rst;
  logic [3:0]  reg_addr;
  logic [15:0] reg_wdata;
  logic        reg_wr;
  logic        reg_rd;
  logic [15:0] reg_rdata;
  logic        buf_valid;
  logic [7:0]  buf_data;
  logic        buf_last;
  logic        buf_ready;
  logic        link_pin;
  logic        tp_tx_en;
  logic [7:0]  tp_tx_data;
  logic        loop_valid;
  logic [7:0]  loop_data;
  logic        link_up;
  logic        led_out_first;
  logic        led_out_second;
  logic [7:0]  wire_q[$];
  logic [15:0] rd_q[$];
  logic [31:0] rnd = 32'h0000000a;
  logic [7:0]  e;
  logic        exp_loop = 1'b1;
  logic        rd_d = 1'b0;
  logic        crc_bad = 1'b0;
  int          num_errors = 0;
  int          comparisons = 0;
  // Packed as mac3, ctrl, length, slow
  logic [31:0] tbl [7] = '{32'h20000a00, 32'h00070a01, 32'h20011400,
                           32'h10f60800, 32'h60000c01, 32'he0004600,
                           32'h00000900};

  // Short jabber limit keeps the run brief
  txfc_top #(.JABBER_LIMIT(200)) i_txfc_top (
    .clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
    .buf_valid(buf_valid), .buf_data(buf_data), .buf_last(buf_last),
    .buf_ready(buf_ready), .link_pin(link_pin), .tp_tx_en(tp_tx_en),
    .tp_tx_data(tp_tx_data), .loop_valid(loop_valid),
    .loop_data(loop_data), .link_up(link_up),
    .led_out_first(led_out_first), .led_out_second(led_out_second));

  txfc_host_model i_txfc_host_model (
    .clock(clock), .buf_ready(buf_ready), .buf_valid(buf_valid),
    .buf_data(buf_data), .buf_last(buf_last));

  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end

  task automatic check(input string what, input logic [15:0] seen,
                       input logic [15:0] exp);
    comparisons++;
    if (seen !== exp) begin
      num_errors++;
      $display("[FAIL] %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic wr(input logic [3:0] a, input logic [15:0] d);
    reg_wr    <= 1'b1;
    reg_addr  <= a;
    reg_wdata <= d;
    @(posedge clock);
    reg_wr <= 1'b0;
    @(posedge clock);
  endtask

  task automatic rd(input logic [3:0] a, input logic [15:0] exp);
    rd_q.push_back(exp);
    reg_rd   <= 1'b1;
    reg_addr <= a;
    @(posedge clock);
    reg_rd <= 1'b0;
    @(posedge clock);
  endtask

  function automatic logic [7:0] nextr();
    rnd ^= rnd << 13;
    rnd ^= rnd >> 17;
    rnd ^= rnd << 5;
    return rnd[7:0];
  endfunction

  function automatic logic [31:0] crcb(logic [31:0] c, logic [7:0] b);
    c ^= {24'h000000, b};
    repeat (8) c = c[0] ? (c >> 1) ^ CRC_POLY : c >> 1;
    return c;
  endfunction

  // Expected wire image worked out from global and per-frame settings
  task automatic frame(input logic [7:0] m, input logic [7:0] ctrl,
                       input int n, input bit slow, input bit on);
    logic [7:0]  pl[$];
    logic [31:0] c;
    logic [7:0]  b;
    int          padto;
    int          i;
    bit          fcs;
    wr(REG_MAC_CTL_THR, {8'h00, m});
    padto = 0;
    if (ctrl[CB_OVR]) begin
      if (ctrl[CB_PAD]) padto = 60;
      fcs = ctrl[CB_CRC];
    end else begin
      if (m[MC3_PAD_LSB +: 3] == 3'b001) padto = 60;
      if (m[MC3_PAD_LSB +: 2] == 2'b11) padto = 64;
      fcs = m[MC3_CRC_BIT] | m[MC3_PAD_LSB];
    end
    c = CRC_INIT;
    if (on) repeat (PREAMBLE_LEN) wire_q.push_back(PREAMBLE_BYTE);
    if (on) wire_q.push_back(SFD_BYTE);
    for (i = 0; i < n || i < padto; i++) begin
      b = 8'h00;
      if (i < n) b = nextr();
      if (i < n) pl.push_back(b);
      c = crcb(c, b);
      if (on) wire_q.push_back(b);
    end
    for (i = 0; i < 4; i++) if (on && fcs) wire_q.push_back(~c[8*i +: 8]);
    // No appended CRC: last four bytes are checked as one
    if (!fcs && n >= padto && c != CRC_RESIDUE) crc_bad = 1'b1;
    i_txfc_host_model.send(ctrl, pl, slow);
    for (i = 0; i < 300 && wire_q.size() > 0; i++) @(posedge clock);
    check("wire bytes left", 16'(wire_q.size()), 16'h0000);
    repeat (90) @(posedge clock);
  endtask

  always @(posedge clock) begin
    if (rd_d) check("reg_rdata", reg_rdata, rd_q.pop_front());
    rd_d <= reg_rd;
    if (!rst && (tp_tx_en || loop_valid))
      check("loop_valid", loop_valid, exp_loop);
    if (!rst && tp_tx_en) begin
      e = (wire_q.size() > 0) ? wire_q.pop_front() : 8'hxx;
      check("tp_tx_data", tp_tx_data, e);
      if (exp_loop) check("loop_data", loop_data, e);
    end
  end

  task automatic results();
    $display("comparisons %0d num_errors %0d", comparisons, num_errors);
    if (num_errors == 0 && comparisons > 0) begin
      $display("SIMULATION PASSED");
    end else begin
      $display("SIMULATION FAILED");
    end
    $finish;
  endtask

  initial begin
    repeat (20000) @(posedge clock);
    num_errors++;
    results();
  end

  initial begin
    int k;
    rst = 1'b1;
    reg_addr = 4'h0;
    reg_wdata = 16'h0000;
    reg_wr = 1'b0;
    reg_rd = 1'b0;
    link_pin = 1'b0;
    repeat (2) @(posedge clock);
    rst <= 1'b0;
    @(posedge clock);
    rd(REG_PHY_CTL_TWO, 16'h0000);
    rd(REG_LED_CFG, LED_RESET);
    rd(REG_MAX_LEN, MAXLEN_RST);
    rd(4'hc, 16'h0000);
    wr(REG_PHY_CTL_TWO, 16'hffff);
    rd(REG_PHY_CTL_TWO, PC2_WR_MASK);
    repeat (4) @(posedge clock);
    check("link_up forced", link_up, 1'b1);
    check("led first tx idle", led_out_first, 1'b0);
    check("led second on", led_out_second, 1'b1);
    wr(REG_PHY_CTL_TWO, 16'h0000);
    repeat (4) @(posedge clock);
    check("link_up released", link_up, 1'b0);
    link_pin <= 1'b1;
    repeat (6) @(posedge clock);
    check("link_up pin", link_up, 1'b1);
    wr(REG_LED_CFG, 16'h0230);
    repeat (4) @(posedge clock);
    check("led first on", led_out_first, 1'b1);
    check("led second off", led_out_second, 1'b0);
    // settings written ahead of each frame
    for (k = 0; k < 7; k++)
      frame(tbl[k][31:24], tbl[k][23:16], tbl[k][15:8], tbl[k][0], 1'b1);
    wr(REG_PHY_CTL_TWO, 16'h0001 << PC2_ECHO_OFF);
    exp_loop = 1'b0;
    frame(8'h20, 8'h00, 15, 1'b0, 1'b1);
    wr(REG_PHY_CTL_ONE, 16'h0001 << PC1_DUPLEX_BIT);
    rd(REG_PHY_CTL_ONE, 16'h0001 << PC1_DUPLEX_BIT);
    wr(REG_PHY_CTL_TWO, 16'h0000);
    frame(8'h21, 8'h00, 15, 1'b0, 1'b1);
    wr(REG_PHY_CTL_TWO, 16'h0001 << PC2_TX_OFF);
    frame(8'h21, 8'h00, 15, 1'b1, 1'b0);
    // Sticky status: CRC check, giant abort, jabber cut
    rd(REG_STATUS, {11'h000, 2'b00, crc_bad, 2'b10});
    wr(REG_STATUS, 16'h001c);
    wr(REG_MAX_LEN, 16'h0004);
    frame(8'h01, 8'h0b, 5, 1'b0, 1'b0);
    rd(REG_STATUS, 16'h0002);
    frame(8'h01, 8'h03, 5, 1'b0, 1'b0);
    rd(REG_STATUS, 16'h000a);
    wr(REG_STATUS, 16'h001c);
    // Control byte only: engine waits in data until the jabber cut
    frame(8'h11, 8'h00, 0, 1'b0, 1'b0);
    repeat (150) @(posedge clock);
    rd(REG_STATUS, 16'h0012);
    wr(REG_STATUS, 16'h001c);
    wr(REG_PHY_CTL_TWO, (16'h0001 << PC2_TX_OFF) | (16'h0001 << PC2_JAB_OFF));
    frame(8'h11, 8'h00, 0, 1'b0, 1'b0);
    repeat (150) @(posedge clock);
    rd(REG_STATUS, 16'h0003);
    results();
  end
endmodule
